//--- rtl/ipa_aligner.v
// Instruction packing aligner: unpacks 32-bit fetch words into 16-bit and
// 32-bit instructions and long immediates for the decode stage.
// Assumes fetch words arrive in address order from fetch_addr onward.
`include "ipa_defines.vh"

module ipa_aligner (
    input  wire        core_clk,     // Core clock, 50 MHz
    input  wire        nrst,         // Async reset, active low
    input  wire        cfg_big_end,  // 1 selects big-endian ordering
    input  wire        redir_valid,  // Restart fetch at redir_pc
    input  wire [31:0] redir_pc,     // Restart address, halfword aligned
    output wire [31:0] fetch_addr,   // Word address of next fetch word
    input  wire        fw_valid,     // Fetch word valid
    output wire        fw_ready,     // Fetch word taken this cycle
    input  wire [31:0] fw_data,      // Fetch word, byte N in bits 7:0, or in bits 31:24 when big-endian
    output wire        dec_valid,    // Unit valid to decode
    input  wire        dec_ready,    // Decode accepts unit
    output wire [31:0] dec_word,     // Instruction or long immediate
    output wire [31:0] dec_pc,       // Address of the unit
    output wire        dec_is32,     // Unit is 32 bits wide
    output wire        dec_is_limm   // Unit is a long immediate
);

// =============================================================
// Length and long immediate decoding
function is32_hw;
    input [15:0] hw;
    begin
        is32_hw = (hw[`IPA_MAJ_HI:`IPA_MAJ_LO] < `IPA_MAJ_FIRST16);
    end
endfunction

// A long immediate is asked for when either source field names its register
function limm_use;
    input [31:0] w;
    reg   [5:0]  src_b;
    reg   [5:0]  src_c;
    begin
        src_b    = {w[`IPA_BREG_HI_MSB:`IPA_BREG_HI_LSB], w[`IPA_BREG_LO_MSB:`IPA_BREG_LO_LSB]};
        src_c    = w[`IPA_CREG_MSB:`IPA_CREG_LSB];
        limm_use = (src_b == `IPA_LIMM_REG) || (src_c == `IPA_LIMM_REG);
    end
endfunction

// =============================================================
// State
// hb0 is always the oldest halfword held; cnt counts the valid ones of hb0..hb2.
// Three slots suffice because a word is taken only while at most one is left over.
reg [15:0] hb0_ff;
reg [15:0] hb1_ff;
reg [15:0] hb2_ff;
reg [1:0]  cnt_ff;
reg        limm_pend_ff;
reg        drop_ff;
reg [31:0] pc_ff;
reg [31:0] faddr_ff;

reg  [15:0] nxt_hb0;
reg  [15:0] nxt_hb1;
reg  [15:0] nxt_hb2;
reg  [1:0]  nxt_cnt;
reg  [47:0] rest;
reg  [1:0]  rem;

wire        big_end;
wire [15:0] fw_first;
wire [15:0] fw_second;
wire        need32;
wire        have;
wire        emit;
wire [1:0]  used;
wire        take;
wire        buf_ready;
wire [31:0] unit_word;
wire        unit_limm;
wire [65:0] buf_out;
wire [31:0] pc_step;
wire [65:0] buf_in;

// Big-endian is honoured only where the variant provides it
assign big_end = cfg_big_end && `IPA_BE_SUPPORT;

// Lower-address halfword first; it sits in bits 15:0 of the word, or in bits 31:16 when big-endian
assign fw_first  = big_end ? fw_data[31:16] : fw_data[15:0];
assign fw_second = big_end ? fw_data[15:0]  : fw_data[31:16];

// A pending limm is taken as 32 bits whatever its top bits look like
assign need32 = limm_pend_ff || is32_hw(hb0_ff);
assign have   = need32 ? (cnt_ff >= 2'd2) : (cnt_ff != 2'd0);
// Emission waits for a free buffer slot; a redirect overrides it
assign emit   = have && buf_ready && !redir_valid;
assign used   = emit ? (need32 ? 2'd2 : 2'd1) : 2'd0;
assign pc_step = need32 ? `IPA_STEP32 : `IPA_STEP16;

// A word is taken only when at most one halfword remains afterwards
assign take     = fw_valid && fw_ready;
assign fw_ready = !redir_valid && ((cnt_ff - used) <= 2'd1);

// First halfword is the upper half of the reassembled word
assign unit_word = need32 ? {hb0_ff, hb1_ff} : {16'h0000, hb0_ff};
assign unit_limm = limm_pend_ff;

// Payload order: limm flag, width flag, unit address, unit word
assign buf_in = {unit_limm, need32, pc_ff, unit_word};

assign fetch_addr = faddr_ff;

// =============================================================
// Halfword queue update
// The emitted unit's halfwords leave first, then the taken word joins behind the rest
always @* begin
    rest = {hb2_ff, hb1_ff, hb0_ff};
    if (used == 2'd2) begin
        rest = {32'h00000000, hb2_ff};
    end else if (used == 2'd1) begin
        rest = {16'h0000, hb2_ff, hb1_ff};
    end
    rem     = cnt_ff - used;
    nxt_hb0 = rest[15:0];
    nxt_hb1 = rest[31:16];
    nxt_hb2 = rest[47:32];
    nxt_cnt = rem;
    if (take) begin
        // After a jump to an odd halfword the first half is skipped
        if (drop_ff) begin
            case (rem)
                2'd0: nxt_hb0 = fw_second;
                2'd1: nxt_hb1 = fw_second;
                default: nxt_hb2 = fw_second;
            endcase
            nxt_cnt = rem + 2'd1;
        end else begin
            case (rem)
                2'd0: begin
                    nxt_hb0 = fw_first;
                    nxt_hb1 = fw_second;
                end
                default: begin
                    nxt_hb1 = fw_first;
                    nxt_hb2 = fw_second;
                end
            endcase
            nxt_cnt = rem + 2'd2;
        end
    end
end

always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
        hb0_ff       <= 16'h0000;
        hb1_ff       <= 16'h0000;
        hb2_ff       <= 16'h0000;
        cnt_ff       <= 2'd0;
        limm_pend_ff <= 1'b0;
        pc_ff        <= `IPA_PC_RST;
    end else if (redir_valid) begin
        cnt_ff       <= 2'd0;
        limm_pend_ff <= 1'b0;
        pc_ff        <= {redir_pc[31:1], 1'b0};
    end else begin
        hb0_ff <= nxt_hb0;
        hb1_ff <= nxt_hb1;
        hb2_ff <= nxt_hb2;
        cnt_ff <= nxt_cnt;
        if (emit) begin
            pc_ff <= pc_ff + pc_step;
            // Only an instruction, never a limm itself, can call for a limm
            limm_pend_ff <= !limm_pend_ff && need32 && limm_use(unit_word);
        end
    end
end

// =============================================================
// Fetch address: one word per take; a redirect restarts it at its word
always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
        drop_ff  <= 1'b0;
        faddr_ff <= `IPA_PC_RST;
    end else if (redir_valid) begin
        drop_ff  <= redir_pc[1];
        faddr_ff <= redir_pc & `IPA_WADDR_MASK;
    end else if (take) begin
        drop_ff  <= 1'b0;
        faddr_ff <= faddr_ff + `IPA_STEP32;
    end
end

// =============================================================
// Output buffer: a stalled decode stage loses no unit
ipa_buf2 #(
    .W (`IPA_OUT_W)
) u_buf (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .flush     (redir_valid),
    .in_valid  (emit),
    .in_ready  (buf_ready),
    .in_data   (buf_in),
    .out_valid (dec_valid),
    .out_ready (dec_ready),
    .out_data  (buf_out)
);

assign dec_is_limm = buf_out[`IPA_OUT_LIMM];
assign dec_is32    = buf_out[`IPA_OUT_IS32];
assign dec_pc      = buf_out[`IPA_OUT_PC_MSB:`IPA_OUT_PC_LSB];
assign dec_word    = buf_out[`IPA_OUT_WD_MSB:0];

endmodule // ipa_aligner

//--- rtl/ipa_defines.vh
// Constants for the instruction packing aligner.
// Assumes inclusion by bare name from the rtl files of this block.
`ifndef IPA_DEFINES_VH
`define IPA_DEFINES_VH

// =============================================================
// Widths
`define IPA_WORD_W      32
`define IPA_HW_W        16
`define IPA_OUT_W       66

// =============================================================
// Length decoding on the first halfword
`define IPA_MAJ_HI      15
`define IPA_MAJ_LO      11
`define IPA_MAJ_FIRST16 5'h0c

// =============================================================
// Long immediate indicator in a reassembled 32-bit word
`define IPA_LIMM_REG    6'h3e

// =============================================================
// Source operand fields of a reassembled 32-bit instruction
`define IPA_BREG_HI_MSB 14
`define IPA_BREG_HI_LSB 12
`define IPA_BREG_LO_MSB 26
`define IPA_BREG_LO_LSB 24
`define IPA_CREG_MSB    11
`define IPA_CREG_LSB    6

// =============================================================
// Fields of a unit held in the output buffer
`define IPA_OUT_LIMM    65
`define IPA_OUT_IS32    64
`define IPA_OUT_PC_MSB  63
`define IPA_OUT_PC_LSB  32
`define IPA_OUT_WD_MSB  31

// =============================================================
// Reset values and address steps
`define IPA_PC_RST      32'h00000000
`define IPA_STEP16      32'h00000002
`define IPA_STEP32      32'h00000004
`define IPA_WADDR_MASK  32'hfffffffc
`define IPA_BE_SUPPORT  1'b1

`endif

//--- rtl/ipa_buf2.v
// Two-entry valid/ready buffer between aligner and decode stage.
// Assumes one clock, asynchronous active-low reset.
`include "ipa_defines.vh"

module ipa_buf2 #(
    parameter W = `IPA_OUT_W
) (
    input  wire         core_clk,  // Core clock
    input  wire         nrst,      // Async reset, active low
    input  wire         flush,     // Drop all held entries
    input  wire         in_valid,  // Write side valid
    output wire         in_ready,  // Write side ready
    input  wire [W-1:0] in_data,   // Write side data
    output wire         out_valid, // Read side valid
    input  wire         out_ready, // Read side ready
    output wire [W-1:0] out_data   // Read side data, from a register
);

// =============================================================
// Storage
reg [W-1:0] ent0_ff;
reg [W-1:0] ent1_ff;
reg [1:0]   cnt_ff;
wire        push;
wire        pop;

assign in_ready  = (cnt_ff != 2'd2);
assign out_valid = (cnt_ff != 2'd0);
assign out_data  = ent0_ff;
assign push      = in_valid && in_ready;
assign pop       = out_valid && out_ready;

always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
        ent0_ff <= {W{1'b0}};
        ent1_ff <= {W{1'b0}};
        cnt_ff  <= 2'd0;
    end else if (flush) begin
        cnt_ff <= 2'd0;
    end else begin
        // Head shifts on pop so the read data always come from ent0
        if (pop) begin
            ent0_ff <= (cnt_ff == 2'd2) ? ent1_ff : in_data;
        end else if (push && cnt_ff == 2'd0) begin
            ent0_ff <= in_data;
        end
        if (push && ((cnt_ff == 2'd1 && !pop) || (cnt_ff == 2'd2 && pop))) begin
            ent1_ff <= in_data;
        end
        cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
end

endmodule // ipa_buf2

//--- sim/ipa_aligner_monitor.sv
// Port checker for the aligner: fetch stepping, redirect, unit order and hold.
// Assumes one clock domain; bound to every ipa_aligner instance.
`include "ipa_defines.vh"

module ipa_aligner_monitor (
    input wire logic        core_clk,    // Clock
    input wire logic        nrst,        // Reset
    input wire logic        cfg_big_end, // Order
    input wire logic        redir_valid, // Restart
    input wire logic [31:0] redir_pc,    // Restart pc
    input wire logic [31:0] fetch_addr,  // Fetch address
    input wire logic        fw_valid,    // Word valid
    input wire logic        fw_ready,    // Word taken
    input wire logic [31:0] fw_data,     // Word
    input wire logic        dec_valid,   // Unit valid
    input wire logic        dec_ready,   // Unit taken
    input wire logic [31:0] dec_word,    // Unit
    input wire logic [31:0] dec_pc,      // Unit pc
    input wire logic        dec_is32,    // Wide unit
    input wire logic        dec_is_limm  // Immediate
);
    timeunit 1ns;
    timeprecision 1ns;
    // =============================================================
    // Helpers
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence s_fetch_take;
        fw_valid && fw_ready && !redir_valid;
    endsequence
    sequence s_dec_stall;
        dec_valid && !dec_ready && !redir_valid;
    endsequence
    logic [31:0] nxt_pc_ff;
    // Expected pc of the next unit, so a skipped or doubled halfword shows
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            nxt_pc_ff <= `IPA_PC_RST;
        end else if (redir_valid) begin
            nxt_pc_ff <= redir_pc & 32'hfffffffe;
        end else if (dec_valid && dec_ready) begin
            nxt_pc_ff <= dec_pc + (dec_is32 ? `IPA_STEP32 : `IPA_STEP16);
        end
    end
    // =============================================================
    // Assertions
    a_redir_refuse: assert property (redir_valid |-> !fw_ready)
        else $error("word taken during redirect");
    a_addr_step: assert property (s_fetch_take |=> fetch_addr == $past(fetch_addr) + 32'h4)
        else $error("fetch address did not step by four");
    a_addr_hold: assert property (!fw_valid && !redir_valid |=> $stable(fetch_addr))
        else $error("fetch address moved without a take");
    a_redir_load: assert property (redir_valid |=>
        fetch_addr == ($past(redir_pc) & `IPA_WADDR_MASK) && !dec_valid)
        else $error("redirect not applied");
    a_unit_hold: assert property (s_dec_stall |=> dec_valid && $stable(dec_word) && $stable(dec_pc))
        else $error("unit changed while stalled");
    a_limm_wide: assert property (dec_valid && dec_is_limm |-> dec_is32)
        else $error("immediate not marked wide");
    a_len_major: assert property (dec_valid && !dec_is_limm |-> (dec_is32 ?
        dec_word[31:27] < `IPA_MAJ_FIRST16 :
        dec_word[31:16] == 16'h0 && dec_word[15:11] >= `IPA_MAJ_FIRST16))
        else $error("length does not follow major opcode");
    a_pc_order: assert property (dec_valid |-> dec_pc == nxt_pc_ff)
        else $error("unit address out of order");
endmodule // ipa_aligner_monitor

bind ipa_aligner ipa_aligner_monitor u_ipa_aligner_monitor (.core_clk, .nrst, .cfg_big_end,
    .redir_valid, .redir_pc, .fetch_addr, .fw_valid, .fw_ready, .fw_data, .dec_valid,
    .dec_ready, .dec_word, .dec_pc, .dec_is32, .dec_is_limm);

//--- sim/ipa_imem.sv
// Instruction memory model: offers the word at fetch_addr, stalling on request.
// Assumes fetch_addr moves only on a take or a redirect; the bench fills mem.
module ipa_imem (
    input  wire logic        core_clk,   // Clock
    input  wire logic        nrst,       // Reset
    input  wire logic        stall,      // Withhold next word
    input  wire logic [31:0] fetch_addr, // Word wanted
    input  wire logic        fw_ready,   // Word taken
    output logic             fw_valid,   // Word offered
    output logic [31:0]      fw_data     // Word
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [0:127];
    logic [31:0] junk_ff;
    // Idle data churns so a stale word can never pass for a fresh one
    assign fw_data = fw_valid ? mem[fetch_addr[8:2]] : junk_ff;
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fw_valid <= 1'b0;
            junk_ff  <= 32'h5a5a5a5a;
        end else begin
            junk_ff <= ~junk_ff;
            if (!fw_valid || fw_ready) begin
                fw_valid <= !stall;
            end
        end
    end
endmodule // ipa_imem

//--- sim/instruction_packing_aligner_tb.sv
// Bench for ipa_aligner: random mixed streams in both halfword orders.
// Assumes the memory model and bound checker; units checked from a queue.
module instruction_packing_aligner_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 0, nrst = 0, cfg_big_end = 0, redir_valid = 0;
    logic        dec_ready = 0, stall = 0, park = 0;
    logic [31:0] redir_pc = 32'h0;
    wire  [31:0] fetch_addr, fw_data, dec_word, dec_pc;
    wire         fw_valid, fw_ready, dec_valid, dec_is32, dec_is_limm;
    int          miscompares = 0, checks = 0;
    integer      seed = 32'h42f92e44;
    logic [65:0] exp_q[$], e;
    logic [15:0] hw[0:255];
    always #10 core_clk = ~core_clk;

    ipa_aligner u_ipa_aligner (.core_clk, .nrst, .cfg_big_end, .redir_valid, .redir_pc,
        .fetch_addr, .fw_valid, .fw_ready, .fw_data, .dec_valid, .dec_ready, .dec_word,
        .dec_pc, .dec_is32, .dec_is_limm);
    ipa_imem u_ipa_imem (.core_clk, .nrst, .stall, .fetch_addr, .fw_ready, .fw_valid, .fw_data);

    // =============================================================
    // Checking
    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic give_verdict;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge core_clk) begin
        // A unit offered at the redirect edge is flushed, not taken
        if (nrst && !redir_valid && dec_valid && dec_ready && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            chk({dec_word, dec_pc, dec_is32, dec_is_limm} === e, "unit");
        end
    end

    // =============================================================
    // Stimulus
    always @(posedge core_clk) begin
        stall <= ($random(seed) % 4) == 0;
        dec_ready <= !park && ($random(seed) & 1);
    end
    // Padding after the stream is never expected, so the queue ignores it
    task automatic run(input logic big, input int base, input int n);
        logic [31:0] w, r;
        logic [65:0] tmp[$];
        int i;
        i = base;
        for (int k = 0; k < 256; k++) hw[k] = 16'h7800;
        repeat (n) begin
            r = $random(seed);
            w = $random(seed);
            if (r[1]) begin
                hw[i] = {5'h0c | r[20:16], w[10:0]};
                tmp.push_back({16'h0, hw[i], 32'(2 * i), 2'b00});
                i++;
            end else begin
                w[31:27] = r[20:16] & 5'h0b;
                w[14:6] = {3'h0, r[2] ? 6'h3e : 6'h00};
                hw[i] = w[31:16];
                hw[i + 1] = w[15:0];
                tmp.push_back({w, 32'(2 * i), 2'b10});
                i += 2;
                if (r[2]) begin
                    hw[i] = r[31:16];
                    hw[i + 1] = r[15:0];
                    tmp.push_back({r, 32'(2 * i), 2'b11});
                    i += 2;
                end
            end
        end
        for (int k = 0; k < 128; k++)
            u_ipa_imem.mem[k] = big ? {hw[2*k], hw[2*k+1]} : {hw[2*k+1], hw[2*k]};
        @(posedge core_clk);
        cfg_big_end <= big;
        redir_valid <= 1'b1;
        redir_pc <= 32'(2 * base);
        park <= 1'b1;
        @(posedge core_clk);
        redir_valid <= 1'b0;
        exp_q = tmp;
        repeat (20) @(posedge core_clk);
        #1;
        chk(dec_valid === 1'b1 && fw_ready === 1'b0, "no back-pressure");
        park <= 1'b0;
        for (int t = 0; t < 3000 && exp_q.size() > 0; t++) @(posedge core_clk);
        chk(exp_q.size() == 0, "units missing");
    endtask

    initial begin
        repeat (4) @(posedge core_clk);
        chk(fetch_addr === 32'h0 && dec_valid === 1'b0, "reset state");
        nrst <= 1'b1;
        run(1'b0, 0, 40);
        run(1'b1, 1, 40);
        run(1'b0, 3, 40);
        give_verdict();
    end
    initial begin
        #400us;
        miscompares++;
        give_verdict();
    end
endmodule // instruction_packing_aligner_tb
